// *** common/mtm_consts.svh ***
`ifndef MTM_CONSTS_SVH
`define MTM_CONSTS_SVH

// ----------------------------------------
// register word addresses
// ----------------------------------------
`define MTM_A_CTRL      4'h0
`define MTM_A_MODE      4'h1
`define MTM_A_INFN      4'h2
`define MTM_A_OUTA      4'h3
`define MTM_A_OUTB      4'h4
`define MTM_A_LOOP      4'h5
`define MTM_A_CENTRAL_IRQ_CONTROL_REG      4'h6
`define MTM_A_PRESC     4'h7
`define MTM_A_CNT       4'h8
`define MTM_A_CMP0      4'h9
`define MTM_A_CMP1      4'hA
`define MTM_A_REG0      4'hB
`define MTM_A_REG1      4'hC
`define MTM_A_STAT      4'hD

// ----------------------------------------
// field positions
// ----------------------------------------
`define MTM_CTRL_RUN    7
`define MTM_CTRL_TRIG   6
`define MTM_CTRL_DOWN   5
`define MTM_CTRL_SEL    4
`define MTM_CENTRAL_IRQ_CONTROL_REG_GRUN   7
`define MTM_CENTRAL_IRQ_CONTROL_REG_EVWRAP 0
`define MTM_CENTRAL_IRQ_CONTROL_REG_EVCMP0 1

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define MTM_BYTE_RST    8'h00
`define MTM_WORD_RST    16'h0000
`define MTM_WORD_ONES   16'hFFFF
`define MTM_CLK_DIV     2'h3
`define MTM_VEC_CMP     3'h6
`define MTM_VEC_CAP     3'h4
`define MTM_VEC_WRAP    3'h0

`endif

// *** common/mtm_pkg.sv ***
package mtm_pkg;

  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  typedef enum logic [3:0] {
    mode_one_shot,
    mode_continuous,
    mode_trigger,
    mode_retrigger,
    mode_gate,
    mode_capture,
    mode_updown,
    mode_free_run,
    mode_monitor,
    mode_autoclear,
    mode_biload,
    mode_bicapture,
    mode_parallel
  } mtm_mode_t;

  // ----------------------------------------
  // output pin actions
  // ----------------------------------------
  typedef enum logic [1:0] {
    act_hold,
    act_set,
    act_reset,
    act_toggle
  } mtm_act_t;

endpackage

// *** hdl/mtm_pin_edge.sv ***
`timescale 1ns/1ps

module mtm_pin_edge (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // pin and edge choice
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  // synced results
  output logic            level,
  output logic            edge_hit,
  output logic            any_edge
);

  logic meta;
  logic prev;

  // ----------------------------------------
  // two-stage sync, then edge detect
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta  <= 1'b0;
      level <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  assign any_edge = level ^ prev;
  assign edge_hit = (edge_sel[0] & level & ~prev) | (edge_sel[1] & ~level & prev);

endmodule

// *** hdl/mtm_timer.sv ***
`timescale 1ns/1ps
`include "mtm_consts.svh"


module mtm_timer (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // pins
  input  wire logic        input_pin_a,
  input  wire logic        input_pin_b,
  output logic             output_pin_a,
  output logic             output_pin_b,
  // cascade and events
  input  wire logic        cascade_in,
  output logic             cascade_out,
  output logic             chip_event,
  output logic             irq_req,
  output logic [2:0]       irq_vector
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  ctrl;
  logic [3:0]  mode_r;
  logic [7:0]  infn;
  logic [5:0]  act_a;
  logic [5:0]  act_b;
  logic        pin_loopback_bit;
  logic [7:0]  central_irq_control_reg;
  logic [7:0]  presc;
  logic [15:0] cnt;
  logic [15:0] cmp0;
  logic [15:0] cmp1;
  logic [15:0] cr0;
  logic [15:0] cr1;

  // ----------------------------------------
  // internal state
  // ----------------------------------------
  logic [1:0]  div3;
  logic [7:0]  pcnt;
  logic        down;
  logic        stopped;
  logic        ld_tog;
  logic        cap_tog;
  logic [15:0] prev_cnt;
  logic        la, lb, ea, eb, qa, qb;
  logic        trig_a, trig_b, gate_a, gate_b, ext_a, ext_b;
  logic        clkud, dirlvl, trigud, quad;
  logic        run, sw_trig, trig, gate_hi, div_tick, presc_in, ptick;
  logic        direct_step, direct_dn, step, dn_step, wrap, eoc, load_hit;
  logic        cap_evt, cmp0_evt, cmp1_evt, stop_mode;
  logic [15:0] load_val;
  mtm_pkg::mtm_mode_t mode;

  function automatic logic wr_at(input logic [3:0] a);
    wr_at = wr && (addr == a);
  endfunction

  function automatic logic apply_act(input logic cur, input logic [1:0] act, input logic hit);
    apply_act = cur;
    if (hit) begin
      case (mtm_pkg::mtm_act_t'(act))
        mtm_pkg::act_set:    apply_act = 1'b1;
        mtm_pkg::act_reset:  apply_act = 1'b0;
        mtm_pkg::act_toggle: apply_act = ~cur;
        default:             apply_act = cur;
      endcase
    end
  endfunction

  assign mode    = mtm_pkg::mtm_mode_t'(mode_r);
  assign run     = ctrl[`MTM_CTRL_RUN] & central_irq_control_reg[`MTM_CENTRAL_IRQ_CONTROL_REG_GRUN];
  assign sw_trig = wr_at(`MTM_A_CTRL) & wdata[`MTM_CTRL_TRIG];

  // ----------------------------------------
  // input pins
  // ----------------------------------------
  mtm_pin_edge u_pin_a (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin      (pin_loopback_bit ? output_pin_a : input_pin_a),
    .edge_sel (infn[5:4]),
    .level    (la),
    .edge_hit (ea),
    .any_edge (qa)
  );

  mtm_pin_edge u_pin_b (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin      (input_pin_b),
    .edge_sel (infn[7:6]),
    .level    (lb),
    .edge_hit (eb),
    .any_edge (qb)
  );

  // ----------------------------------------
  // pin roles
  // ----------------------------------------
  always_comb begin
    {trig_a, trig_b, gate_a, gate_b, ext_a, ext_b} = 6'h00;
    {clkud, dirlvl, trigud, quad} = 4'h0;
    case (infn[3:0])
      4'h1: trig_b = 1'b1;
      4'h2: gate_a = 1'b1;
      4'h3: begin
        gate_a = 1'b1;
        trig_b = 1'b1;
      end
      4'h4: ext_b = 1'b1;
      4'h5: trig_a = 1'b1;
      4'h6: begin
        gate_a = 1'b1;
        ext_b  = 1'b1;
      end
      4'h7: begin
        trig_a = 1'b1;
        trig_b = 1'b1;
      end
      4'h8: clkud = 1'b1;
      4'h9: begin
        dirlvl = 1'b1;
        ext_b  = 1'b1;
      end
      4'hA: begin
        trigud = 1'b1;
        trig_a = 1'b1;
        trig_b = 1'b1;
      end
      4'hB: dirlvl = 1'b1;
      4'hC: quad = 1'b1;
      4'hD: begin
        trig_a = 1'b1;
        ext_b  = 1'b1;
      end
      4'hE: begin
        ext_a  = 1'b1;
        trig_b = 1'b1;
      end
      4'hF: begin
        trig_a = 1'b1;
        gate_b = 1'b1;
      end
      default: quad = 1'b0;
    endcase
  end

  assign trig    = sw_trig | (trig_a & ea) | (trig_b & eb);
  assign gate_hi = (mode == mtm_pkg::mode_gate) & ((gate_a & la) | (gate_b & lb));

  // quadrature: a edge with a!=b counts up, b edge with a==b counts up
  always_comb begin
    direct_step = 1'b0;
    direct_dn   = 1'b0;
    if (quad && (qa ^ qb)) begin
      direct_step = 1'b1;
      direct_dn   = qa ? (la == lb) : (la != lb);
    end else if (clkud && (ea ^ eb)) begin
      direct_step = 1'b1;
      direct_dn   = eb;
    end else if (trigud && mode == mtm_pkg::mode_updown && (ea ^ eb)) begin
      direct_step = 1'b1;
      direct_dn   = eb;
    end
  end

  // ----------------------------------------
  // clock divider and prescaler
  // ----------------------------------------
  assign div_tick = (div3 == `MTM_CLK_DIV - 2'h1);
  assign presc_in = (ext_a & ea) | (ext_b & eb) |
                    (~ext_a & ~ext_b & ((mode == mtm_pkg::mode_parallel) ? cascade_in : div_tick));
  assign ptick    = run & presc_in & (pcnt == presc);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div3 <= 2'h0;
      pcnt <= `MTM_BYTE_RST;
    end else if (run) begin
      div3 <= div_tick ? 2'h0 : div3 + 2'h1;
      if (presc_in) begin
        pcnt <= (pcnt == presc) ? `MTM_BYTE_RST : pcnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cascade_out <= 1'b0;
    end else begin
      cascade_out <= ptick;
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  assign stop_mode = (mode == mtm_pkg::mode_one_shot) | (mode == mtm_pkg::mode_trigger);
  assign step      = run & ~gate_hi & ~stopped & (ptick | direct_step);
  assign dn_step   = direct_step ? direct_dn : down;
  assign eoc       = down ? (cnt == `MTM_WORD_RST) : (cnt == `MTM_WORD_ONES);
  assign wrap      = step & (dn_step ? (cnt == `MTM_WORD_RST) : (cnt == `MTM_WORD_ONES));
  assign load_val  = (mode == mtm_pkg::mode_biload) ? (ld_tog ? cr1 : cr0) : (ctrl[`MTM_CTRL_SEL] ? cr1 : cr0);
  assign load_hit  = (trig & (mode == mtm_pkg::mode_retrigger)) | (trig & (mode == mtm_pkg::mode_trigger) & stopped);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= `MTM_WORD_RST;
    end else if (wr_at(`MTM_A_CNT)) begin
      cnt <= wdata;
    end else if (load_hit) begin
      cnt <= load_val;
    end else if (trig && mode == mtm_pkg::mode_autoclear) begin
      cnt <= down ? `MTM_WORD_ONES : `MTM_WORD_RST;
    end else if (wrap && (mode == mtm_pkg::mode_continuous || mode == mtm_pkg::mode_biload)) begin
      cnt <= load_val;
    end else if (wrap && stop_mode) begin
      cnt <= cnt;
    end else if (step) begin
      cnt <= dn_step ? cnt - 16'h0001 : cnt + 16'h0001;
    end
  end

  // clearing stopped on a CNT or MODE write also blocks a stale trigger-mode reload
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stopped <= 1'b0;
    end else if (wr_at(`MTM_A_CNT) || load_hit || wr_at(`MTM_A_MODE)) begin
      stopped <= 1'b0;
    end else if (wrap && stop_mode) begin
      stopped <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      down <= 1'b0;
    end else if (wr_at(`MTM_A_CTRL)) begin
      down <= wdata[`MTM_CTRL_DOWN];
    end else if (dirlvl) begin
      down <= la;
    end else if (trig && !trigud && mode == mtm_pkg::mode_updown) begin
      down <= ~down;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ld_tog <= 1'b0;
    end else if (wrap && mode == mtm_pkg::mode_biload) begin
      ld_tog <= ~ld_tog;
    end
  end

  // ----------------------------------------
  // capture / load registers
  // ----------------------------------------
  assign cap_evt = trig & ((mode == mtm_pkg::mode_capture) | (mode == mtm_pkg::mode_bicapture));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cr0     <= `MTM_WORD_RST;
      cr1     <= `MTM_WORD_RST;
      cap_tog <= 1'b0;
    end else begin
      if (wr_at(`MTM_A_REG0)) begin
        cr0 <= wdata;
      end
      if (wr_at(`MTM_A_REG1)) begin
        cr1 <= wdata;
      end
      if (mode == mtm_pkg::mode_monitor) begin
        if (ctrl[`MTM_CTRL_SEL]) begin
          cr1 <= cnt;
        end else begin
          cr0 <= cnt;
        end
      end else if (cap_evt && mode == mtm_pkg::mode_capture) begin
        if (ctrl[`MTM_CTRL_SEL]) begin
          cr1 <= cnt;
        end else begin
          cr0 <= cnt;
        end
      end else if (cap_evt) begin
        cap_tog <= ~cap_tog;
        if (cap_tog) begin
          cr1 <= cnt;
        end else begin
          cr0 <= cnt;
        end
      end
    end
  end

  // ----------------------------------------
  // compare, output pins, events
  // ----------------------------------------
  // compare fires only on a fresh counter value, not while parked on it
  assign cmp0_evt = (cnt != prev_cnt) & (cnt == cmp0);
  assign cmp1_evt = (cnt != prev_cnt) & (cnt == cmp1);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_cnt <= `MTM_WORD_RST;
    end else begin
      prev_cnt <= cnt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      output_pin_a <= 1'b0;
      output_pin_b <= 1'b0;
    end else begin
      output_pin_a <= apply_act(apply_act(apply_act(output_pin_a, act_a[1:0], wrap),
                                          act_a[3:2], cmp0_evt), act_a[5:4], cmp1_evt);
      output_pin_b <= apply_act(apply_act(apply_act(output_pin_b, act_b[1:0], wrap),
                                          act_b[3:2], cmp0_evt), act_b[5:4], cmp1_evt);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chip_event <= 1'b0;
      irq_req    <= 1'b0;
      irq_vector <= `MTM_VEC_WRAP;
    end else begin
      chip_event <= (central_irq_control_reg[`MTM_CENTRAL_IRQ_CONTROL_REG_EVWRAP] & wrap) | (central_irq_control_reg[`MTM_CENTRAL_IRQ_CONTROL_REG_EVCMP0] & cmp0_evt);
      irq_req    <= wrap | cap_evt | cmp0_evt | cmp1_evt;
      if (cmp0_evt || cmp1_evt) begin
        irq_vector <= `MTM_VEC_CMP;
      end else if (cap_evt) begin
        irq_vector <= `MTM_VEC_CAP;
      end else if (wrap) begin
        irq_vector <= `MTM_VEC_WRAP;
      end
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl             <= `MTM_BYTE_RST;
      mode_r           <= 4'h0;
      infn             <= `MTM_BYTE_RST;
      act_a            <= 6'h00;
      act_b            <= 6'h00;
      pin_loopback_bit <= 1'b0;
      central_irq_control_reg             <= `MTM_BYTE_RST;
      presc            <= `MTM_BYTE_RST;
      cmp0             <= `MTM_WORD_RST;
      cmp1             <= `MTM_WORD_RST;
    end else if (wr) begin
      case (addr)
        `MTM_A_CTRL:  ctrl <= wdata[7:0] & 8'hBF;
        `MTM_A_MODE:  mode_r <= wdata[3:0];
        `MTM_A_INFN:  infn <= wdata[7:0];
        `MTM_A_OUTA:  act_a <= wdata[5:0];
        `MTM_A_OUTB:  act_b <= wdata[5:0];
        `MTM_A_LOOP:  pin_loopback_bit <= wdata[0];
        `MTM_A_CENTRAL_IRQ_CONTROL_REG:  central_irq_control_reg <= wdata[7:0];
        `MTM_A_PRESC: presc <= wdata[7:0];
        `MTM_A_CMP0:  cmp0 <= wdata;
        `MTM_A_CMP1:  cmp1 <= wdata;
        default:      presc <= presc;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= `MTM_WORD_RST;
    end else if (rd) begin
      case (addr)
        `MTM_A_CTRL:  rdata <= {8'h00, ctrl};
        `MTM_A_MODE:  rdata <= {12'h000, mode_r};
        `MTM_A_INFN:  rdata <= {8'h00, infn};
        `MTM_A_OUTA:  rdata <= {10'h000, act_a};
        `MTM_A_OUTB:  rdata <= {10'h000, act_b};
        `MTM_A_LOOP:  rdata <= {15'h0000, pin_loopback_bit};
        `MTM_A_CENTRAL_IRQ_CONTROL_REG:  rdata <= {8'h00, central_irq_control_reg};
        `MTM_A_PRESC: rdata <= {8'h00, presc};
        `MTM_A_CNT:   rdata <= cnt;
        `MTM_A_CMP0:  rdata <= cmp0;
        `MTM_A_CMP1:  rdata <= cmp1;
        `MTM_A_REG0:  rdata <= cr0;
        `MTM_A_REG1:  rdata <= cr1;
        `MTM_A_STAT:  rdata <= {11'h000, cap_tog, ld_tog, stopped, down, eoc};
        default:      rdata <= `MTM_WORD_RST;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_halt_when_off: assert property (!run && !wr && !trig |=> $stable(cnt) && $stable(pcnt))
    else $error("counter moved while not running");
  a_oneshot_stays: assert property (mode == mtm_pkg::mode_one_shot && stopped && !wr |=> $stable(cnt))
    else $error("one-shot counter moved after end of count");
  a_cont_reload: assert property (mode == mtm_pkg::mode_continuous && wrap && !trig && !wr
                                  |=> cnt == $past(load_val))
    else $error("continuous mode missed reload");
  a_retrig_load: assert property (mode == mtm_pkg::mode_retrigger && trig && !wr |=> cnt == $past(load_val))
    else $error("retrigger did not reload");
  a_gate_holds: assert property (gate_hi && !trig && !wr ##1 gate_hi |-> $stable(cnt))
    else $error("counter moved while gate high");
  a_capture_copy: assert property (mode == mtm_pkg::mode_capture && trig && !ctrl[`MTM_CTRL_SEL]
                                   && !wr_at(`MTM_A_REG0) |=> cr0 == $past(cnt))
    else $error("capture missed counter value");
  a_autoclear_zero: assert property (mode == mtm_pkg::mode_autoclear && trig && !down && !wr_at(`MTM_A_CNT)
                                     |=> cnt == 16'h0000)
    else $error("autoclear did not clear");
  a_monitor_track: assert property (mode == mtm_pkg::mode_monitor && !ctrl[`MTM_CTRL_SEL] && !wr
                                    |=> cr0 == $past(cnt))
    else $error("monitor register lags counter");
  a_vector_cmp: assert property (cmp0_evt |=> irq_req && irq_vector == 3'h6)
    else $error("compare interrupt vector wrong");

  c_wrap_seen:    cover property (wrap ##1 irq_req);
  c_biload_twice: cover property (wrap && mode == mtm_pkg::mode_biload ##[1:300] wrap);
  c_capture_trig: cover property (cap_evt);
  c_quad_down:    cover property (quad && direct_step && direct_dn);

endmodule

// *** sim/mtm_pin_model.sv ***
`timescale 1ns/1ps

module mtm_pin_model (
  // clock
  input  wire logic sys_clk,
  // pins toward the timer
  output logic      pin_a,
  output logic      pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // ----------------------------------------
  // pulse: high for three cycles, then low for five
  // ----------------------------------------
  // long levels so the two-flop sync cannot miss them
  task automatic pulse(input logic on_b);
    @(posedge sys_clk);
    if (on_b) pin_b <= 1'b1; else pin_a <= 1'b1;
    repeat (3) @(posedge sys_clk);
    if (on_b) pin_b <= 1'b0; else pin_a <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask

  // hold a level long enough for sync and edge detect
  task automatic set_pin(input logic on_b, input logic v);
    @(posedge sys_clk);
    pin_b <= on_b ? v : pin_b;
    pin_a <= on_b ? pin_a : v;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`include "mtm_consts.svh"

module tb_top;
  logic        sys_clk;
  logic        rst;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        pin_a;
  logic        pin_b;
  logic        out_a;
  logic        out_b;
  logic        casc_in;
  logic        casc_out;
  logic        chip_event;
  logic        irq_req;
  logic [2:0]  irq_vector;
  logic [15:0] d;
  logic        seen;
  int          fails;
  int          n_compared;
  int          cycles = 0;

  mtm_timer dut_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .input_pin_a(pin_a), .input_pin_b(pin_b), .output_pin_a(out_a),
    .output_pin_b(out_b), .cascade_in(casc_in), .cascade_out(casc_out), .chip_event(chip_event),
    .irq_req(irq_req), .irq_vector(irq_vector));
  mtm_pin_model pins_u (.sys_clk(sys_clk), .pin_a(pin_a), .pin_b(pin_b));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0000);
    rd_reg(4'hE, d);
    check(d, 16'h0000);
  endtask

  // trigger ignored away from end of count, then retrigger on both edge kinds
  task automatic t_trig;
    wr_reg(`MTM_A_INFN, 16'h0041);
    wr_reg(`MTM_A_MODE, 16'h0002);
    wr_reg(`MTM_A_REG0, 16'h4000);
    wr_reg(`MTM_A_CNT, 16'h0010);
    pins_u.pulse(1'b1);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0010);
    wr_reg(`MTM_A_MODE, 16'h0003);
    pins_u.pulse(1'b1);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h4000);
    wr_reg(`MTM_A_INFN, 16'h0081);
    wr_reg(`MTM_A_CNT, 16'h0010);
    pins_u.pulse(1'b1);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h4000);
  endtask

  // counter held still, so software triggers capture known values
  task automatic t_capture;
    wr_reg(`MTM_A_MODE, 16'h000B);
    wr_reg(`MTM_A_CNT, 16'h0100);
    wr_reg(`MTM_A_CTRL, 16'h0040);
    wr_reg(`MTM_A_CNT, 16'h0200);
    wr_reg(`MTM_A_CTRL, 16'h0040);
    rd_reg(`MTM_A_REG0, d);
    check(d, 16'h0100);
    rd_reg(`MTM_A_REG1, d);
    check(d, 16'h0200);
    wr_reg(`MTM_A_MODE, 16'h0005);
    wr_reg(`MTM_A_CNT, 16'h0777);
    wr_reg(`MTM_A_CTRL, 16'h0040);
    rd_reg(`MTM_A_REG0, d);
    check(d, 16'h0777);
  endtask

  task automatic t_autoclear;
    wr_reg(`MTM_A_MODE, 16'h0009);
    wr_reg(`MTM_A_CNT, 16'h0555);
    wr_reg(`MTM_A_CTRL, 16'h0040);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0000);
    wr_reg(`MTM_A_CNT, 16'h0555);
    wr_reg(`MTM_A_CTRL, 16'h0020);
    wr_reg(`MTM_A_CTRL, 16'h0060);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'hFFFF);
  endtask

  // local run alone must not count; global run releases it
  task automatic t_halt;
    wr_reg(`MTM_A_MODE, 16'h0007);
    wr_reg(`MTM_A_CENTRAL_IRQ_CONTROL_REG, 16'h0000);
    wr_reg(`MTM_A_CNT, 16'h0777);
    wr_reg(`MTM_A_CTRL, 16'h0080);
    repeat (20) @(posedge sys_clk);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0777);
    wr_reg(`MTM_A_CENTRAL_IRQ_CONTROL_REG, 16'h0080);
    repeat (20) @(posedge sys_clk);
    rd_reg(`MTM_A_CNT, d);
    check({15'h0000, d > 16'h0777}, 16'h0001);
    wr_reg(`MTM_A_CTRL, 16'h0000);
  endtask

  task automatic t_oneshot;
    wr_reg(`MTM_A_MODE, 16'h0000);
    wr_reg(`MTM_A_CNT, 16'h0005);
    wr_reg(`MTM_A_CTRL, 16'h00A0);
    repeat (40) @(posedge sys_clk);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0000);
    rd_reg(`MTM_A_STAT, d);
    check(d & 16'h0004, 16'h0004);
    wr_reg(`MTM_A_CTRL, 16'h0000);
  endtask

  // wrap reloads, sets pin a, strobes the on-chip event and the wrap vector
  task automatic t_cont;
    wr_reg(`MTM_A_MODE, 16'h0001);
    wr_reg(`MTM_A_REG0, 16'h1234);
    wr_reg(`MTM_A_OUTA, 16'h0001);
    wr_reg(`MTM_A_CENTRAL_IRQ_CONTROL_REG, 16'h0081);
    wr_reg(`MTM_A_CNT, 16'hFFFC);
    wr_reg(`MTM_A_CTRL, 16'h0080);
    seen = 1'b0;
    for (int i = 0; i < 100 && !seen; i++) begin
      @(posedge sys_clk);
      #1 seen = (irq_req === 1'b1);
    end
    check({15'h0000, seen}, 16'h0001);
    check({15'h0000, chip_event}, 16'h0001);
    check({13'h0000, irq_vector}, 16'h0000);
    wr_reg(`MTM_A_CTRL, 16'h0000);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h1234);
    check({15'h0000, out_a}, 16'h0001);
  endtask

  // monitor follows the counter; a high gate pin freezes counting
  task automatic t_gate_mon;
    wr_reg(`MTM_A_MODE, 16'h0008);
    wr_reg(`MTM_A_CNT, 16'h0ABC);
    rd_reg(`MTM_A_REG0, d);
    check(d, 16'h0ABC);
    wr_reg(`MTM_A_MODE, 16'h0004);
    wr_reg(`MTM_A_INFN, 16'h0002);
    pins_u.set_pin(1'b0, 1'b1);
    wr_reg(`MTM_A_CNT, 16'h0100);
    wr_reg(`MTM_A_CTRL, 16'h0080);
    repeat (30) @(posedge sys_clk);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0100);
    pins_u.set_pin(1'b0, 1'b0);
    repeat (30) @(posedge sys_clk);
    rd_reg(`MTM_A_CNT, d);
    check({15'h0000, d > 16'h0100}, 16'h0001);
    wr_reg(`MTM_A_CTRL, 16'h0000);
  endtask

  // pin b rises clock one step each; reloads alternate, pin b toggles
  task automatic t_biload;
    wr_reg(`MTM_A_MODE, 16'h000A);
    wr_reg(`MTM_A_INFN, 16'h0044);
    wr_reg(`MTM_A_OUTB, 16'h0003);
    wr_reg(`MTM_A_REG0, 16'h0100);
    wr_reg(`MTM_A_REG1, 16'h0200);
    wr_reg(`MTM_A_CNT, 16'hFFFF);
    wr_reg(`MTM_A_CTRL, 16'h0080);
    pins_u.pulse(1'b1);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0100);
    check({15'h0000, out_b}, 16'h0001);
    wr_reg(`MTM_A_CNT, 16'hFFFF);
    pins_u.pulse(1'b1);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0200);
    check({15'h0000, out_b}, 16'h0000);
    wr_reg(`MTM_A_CTRL, 16'h0000);
  endtask

  // cascade pulses from the neighbouring prescaler drive this counter
  task automatic t_par;
    wr_reg(`MTM_A_MODE, 16'h000C);
    wr_reg(`MTM_A_INFN, 16'h0000);
    wr_reg(`MTM_A_CNT, 16'h0000);
    wr_reg(`MTM_A_CTRL, 16'h0080);
    repeat (5) begin
      @(posedge sys_clk);
      casc_in <= 1'b1;
      @(posedge sys_clk);
      casc_in <= 1'b0;
      #1 check({15'h0000, casc_out}, 16'h0001);
    end
    @(posedge sys_clk);
    #1 check({15'h0000, casc_out}, 16'h0000);
    wr_reg(`MTM_A_CTRL, 16'h0000);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0005);
  endtask

  // slow prescaler keeps internal ticks out; runs after t_par on purpose
  task automatic t_quad;
    wr_reg(`MTM_A_MODE, 16'h0007);
    wr_reg(`MTM_A_PRESC, 16'h00FF);
    wr_reg(`MTM_A_INFN, 16'h000C);
    wr_reg(`MTM_A_CNT, 16'h0010);
    wr_reg(`MTM_A_CTRL, 16'h0080);
    for (int i = 0; i < 4; i++) begin
      pins_u.set_pin(i[0], ~i[1]);
    end
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0014);
    for (int i = 0; i < 4; i++) begin
      pins_u.set_pin(~i[0], ~i[1]);
    end
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h0010);
    wr_reg(`MTM_A_MODE, 16'h0006);
    wr_reg(`MTM_A_INFN, 16'h005A);
    pins_u.pulse(1'b0);
    pins_u.pulse(1'b1);
    pins_u.pulse(1'b1);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h000F);
    wr_reg(`MTM_A_CTRL, 16'h0000);
    wr_reg(`MTM_A_INFN, 16'h0041);
    pins_u.pulse(1'b1);
    rd_reg(`MTM_A_STAT, d);
    check(d & 16'h0002, 16'h0002);
  endtask

  // falling output a loops back as a trigger on input a
  task automatic t_loop;
    wr_reg(`MTM_A_MODE, 16'h0003);
    wr_reg(`MTM_A_REG0, 16'h4321);
    wr_reg(`MTM_A_INFN, 16'h0025);
    wr_reg(`MTM_A_LOOP, 16'h0001);
    wr_reg(`MTM_A_OUTA, 16'h0008);
    wr_reg(`MTM_A_CMP0, 16'h0300);
    wr_reg(`MTM_A_CNT, 16'h0300);
    repeat (8) @(posedge sys_clk);
    check({15'h0000, out_a}, 16'h0000);
    rd_reg(`MTM_A_CNT, d);
    check(d, 16'h4321);
  endtask

  // ----------------------------------------
  // clock, reset, watchdog on run length
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    fails = 0;
    n_compared = 0;
    casc_in = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_trig();
    t_capture();
    t_autoclear();
    t_halt();
    t_oneshot();
    t_cont();
    t_gate_mon();
    t_biload();
    t_par();
    t_quad();
    t_loop();
    stop_test();
  end
endmodule
